// File: logic/dbs_device.sv
`timescale 1ns/1ns
`include "dbs_map.svh"


module dbs_device #(
    parameter int DW = `DBS_DATA_W,
    parameter int AW = `DBS_ADDR_W
) (
    input  wire logic          ref_clk,        // System clock
    input  wire logic          reset_n,        // Async reset, active low
    dbs_link_if.device         link,           // Memory pins
    output      logic          write_commit,   // Burst written to array
    output      logic [AW-1:0] write_addr,     // Address of last write
    output      logic          read_launch     // Read address captured
);

    localparam int PL = `DBS_PIPE_LEN;
    localparam int SW = 8 + AW + DW;
    localparam int MW = AW + 1;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [SW-1:0] pin_raw;
    logic [SW-1:0] meta_q;
    logic [SW-1:0] sync_q;
    logic          k_s;
    logic          kn_s;
    logic          c_s;
    logic          cn_s;
    logic          single_s;
    logic          pll_s;
    logic          rps_n_s;
    logic          wps_n_s;
    logic [AW-1:0] addr_s;
    logic [DW-1:0] d_s;

    // Bundle every pin into one vector
    assign pin_raw = {link.k, link.c, link.k_n, link.c_n, link.single_clock, link.pll_disable,
                      link.read_port_select_n, link.write_port_select_n, link.addr, link.d};

    // Two flip-flops before any logic looks at the pins
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // Idle pin levels, so no false clock edge follows reset
            meta_q <= {8'h37, {(SW - 8){1'h0}}};
            sync_q <= {8'h37, {(SW - 8){1'h0}}};
        end
        else
        begin
            meta_q <= pin_raw;
            sync_q <= meta_q;
        end
    end

    // Unpack the synchronised pins; clocks share a common delay
    assign {k_s, c_s, kn_s, cn_s, single_s, pll_s, rps_n_s, wps_n_s, addr_s, d_s} = sync_q;

    // ----------------------------------------------------------------
    // Clock edge detection
    // ----------------------------------------------------------------
    logic [3:0] clk_prev_q;
    logic       k_rise;
    logic       kn_rise;
    logic       c_rise;
    logic       cn_rise;
    logic       out_true;
    logic       out_comp;
    logic       out_edge;

    // Previous level of each clock
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            clk_prev_q <= 4'h5;
        else
            clk_prev_q <= {k_s, kn_s, c_s, cn_s};
    end

    // Rising edges only; complement rise stands for true fall
    assign k_rise   = k_s & ~clk_prev_q[3];
    assign kn_rise  = kn_s & ~clk_prev_q[2];
    assign c_rise   = c_s & ~clk_prev_q[1];
    assign cn_rise  = cn_s & ~clk_prev_q[0];

    // Output launch edges from the c pair, or the k pair alone
    assign out_true = single_s ? k_rise : c_rise;
    assign out_comp = single_s ? kn_rise : cn_rise;
    assign out_edge = out_true | out_comp;

    // ----------------------------------------------------------------
    // Write port
    // ----------------------------------------------------------------
    logic          wr_pend_q;
    logic [DW-1:0] wd0_q;
    logic          wr_now;
    logic [DW-1:0] mem_q [0:(2**MW)-1];

    // Second half of a write burst lands on the k_n edge
    assign wr_now = kn_rise & wr_pend_q;

    // Select and first word on k; address and second word on k_n
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_pend_q <= 1'h0;
            wd0_q     <= '0;
        end
        else if (k_rise)
        begin
            wr_pend_q <= ~wps_n_s;
            wd0_q     <= d_s;
        end
        else if (kn_rise)
            wr_pend_q <= 1'h0;
    end

    // Self-timed commit of both words into the array
    always_ff @(posedge ref_clk)
    begin
        if (wr_now)
        begin
            mem_q[{addr_s, 1'h0}] <= wd0_q;
            mem_q[{addr_s, 1'h1}] <= d_s;
        end
    end

    // Report the commit to the user side
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            write_commit <= 1'h0;
            write_addr   <= '0;
        end
        else
        begin
            write_commit <= wr_now;
            if (wr_now)
                write_addr <= addr_s;
        end
    end

    // ----------------------------------------------------------------
    // Read port pipeline
    // ----------------------------------------------------------------
    dbs_pkg::dbs_lat_t lat;
    logic              rd_cap;
    logic              pv_q [0:PL-1];
    logic [DW-1:0]     pd_q [0:PL-1];
    logic              pv_d [0:PL-1];
    logic [DW-1:0]     pd_d [0:PL-1];

    // Latency in output half cycles from the pll_disable strap
    assign lat    = pll_s ? `DBS_LAT_HALF_PLL_ON
                          : `DBS_LAT_HALF_PLL_OFF;
    assign rd_cap = k_rise & ~rps_n_s;

    // Array word, forwarding a write that lands this very cycle
    function automatic logic [DW-1:0] fetch(input logic [AW-1:0] a, input logic h);
        logic [DW-1:0] w;
        w = mem_q[{a, h}];
        if (wr_now && a == addr_s)
            w = h ? d_s : wd0_q;
        return w;
    endfunction

    // Shift one slot per output edge; both words are read at capture,
    // so a later write can never tear a burst in flight
    always_comb
    begin
        for (int i = 0; i < PL - 1; i++)
        begin
            pv_d[i] = out_edge ? pv_q[i + 1] : pv_q[i];
            pd_d[i] = out_edge ? pd_q[i + 1] : pd_q[i];
        end
        pv_d[PL - 1] = out_edge ? 1'h0 : pv_q[PL - 1];
        pd_d[PL - 1] = out_edge ? '0 : pd_q[PL - 1];
        if (rd_cap)
        begin
            pv_d[int'(lat)]     = 1'h1;
            pd_d[int'(lat)]     = fetch(addr_s, 1'h0);
            pv_d[int'(lat) + 1] = 1'h1;
            pd_d[int'(lat) + 1] = fetch(addr_s, 1'h1);
        end
    end

    // Pipeline slots
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < PL; i++)
            begin
                pv_q[i] <= 1'h0;
                pd_q[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < PL; i++)
            begin
                pv_q[i] <= pv_d[i];
                pd_q[i] <= pd_d[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Output registers and echo clocks
    // ----------------------------------------------------------------
    logic [DW-1:0] q_q;
    logic          rv_q;
    logic          cq_q;
    logic          cqn_q;
    logic          launch_q;

    // Launch the word fetched when its address was captured
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q_q  <= '0;
            rv_q <= 1'h0;
        end
        else if (out_edge)
        begin
            rv_q <= pv_q[1];
            if (pv_q[1])
                q_q <= pd_q[1];
        end
    end

    // Echo pair toggles in the same cycle as q
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cq_q  <= 1'h0;
            cqn_q <= 1'h1;
        end
        else if (out_true)
        begin
            cq_q  <= 1'h1;
            cqn_q <= 1'h0;
        end
        else if (out_comp)
        begin
            cq_q  <= 1'h0;
            cqn_q <= 1'h1;
        end
    end

    // Read capture strobe for the user side
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            launch_q <= 1'h0;
        else
            launch_q <= rd_cap;
    end

    // Pin drivers
    assign link.q                 = q_q;
    assign link.read_data_valid   = rv_q;
    assign link.echo_clock_pair   = cq_q;
    assign link.echo_clock_pair_n = cqn_q;
    assign read_launch            = launch_q;

endmodule

// File: logic/dbs_map.svh
`ifndef DBS_MAP_SVH
`define DBS_MAP_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define DBS_DATA_W            18
`define DBS_ADDR_W            8
`define DBS_BURST_LEN         2
`define DBS_RSP_DEPTH         2

// ----------------------------------------------------------------
// Read latency in output-clock half cycles
// ----------------------------------------------------------------
`define DBS_LAT_HALF_PLL_ON   3'h3
`define DBS_LAT_HALF_PLL_OFF  3'h2
`define DBS_PIPE_LEN          5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DBS_CLK_PERIOD_NS     10
`define DBS_LINK_PERIOD_NS    120
`define DBS_LINK_HALF_CYC     ((`DBS_LINK_PERIOD_NS / `DBS_CLK_PERIOD_NS) / 2)

`endif

// File: logic/dbs_pkg.sv
package dbs_pkg;

    // Which clock of the pair rises next
    typedef enum logic [0:0]
    {
        DBS_PH_TRUE = 1'h0,
        DBS_PH_COMP = 1'h1
    } dbs_phase_e;

    // Latency in half cycles
    typedef logic [2:0] dbs_lat_t;

endpackage

// File: logic/dbs_link_if.sv
`timescale 1ns/1ns
`include "dbs_map.svh"

interface dbs_link_if #(
    parameter int DW = `DBS_DATA_W,
    parameter int AW = `DBS_ADDR_W
);
    logic          k;                      // Input clock, true
    logic          k_n;                    // Input clock, complement
    logic          c;                      // Output clock, true
    logic          c_n;                    // Output clock, complement
    logic          single_clock;           // Use k pair for read data
    logic          pll_disable;            // High: 1.5-cycle latency
    logic          read_port_select_n;     // Read select, active low
    logic          write_port_select_n;    // Write select, active low
    logic [AW-1:0] addr;                   // Multiplexed address
    logic [DW-1:0] d;                      // Write data
    logic [DW-1:0] q;                      // Read data
    logic          read_data_valid;        // Read word on q
    logic          echo_clock_pair;        // Echo clock, true
    logic          echo_clock_pair_n;      // Echo clock, complement

    modport device
    (
        input  k, k_n, c, c_n, single_clock, pll_disable,
        input  read_port_select_n, write_port_select_n, addr, d,
        output q, read_data_valid, echo_clock_pair, echo_clock_pair_n
    );

    modport host
    (
        output k, k_n, c, c_n, single_clock, pll_disable,
        output read_port_select_n, write_port_select_n, addr, d,
        input  q, read_data_valid, echo_clock_pair, echo_clock_pair_n
    );
endinterface

// File: logic/dbs_host.sv
`timescale 1ns/1ns
`include "dbs_map.svh"

module dbs_host #(
    parameter int DW   = `DBS_DATA_W,
    parameter int AW   = `DBS_ADDR_W,
    parameter int HALF = `DBS_LINK_HALF_CYC
) (
    input  wire logic          ref_clk,       // System clock
    input  wire logic          reset_n,       // Async reset, active low
    dbs_link_if.host           link,          // Memory pins
    input  wire logic          single_cfg,    // Single clock mode
    input  wire logic          pll_cfg,       // pll_disable level
    input  wire logic          wr_valid,      // Write request
    output      logic          wr_ready,      // Write taken
    input  wire logic [AW-1:0] wr_addr,       // Write address
    input  wire logic [DW-1:0] wr_data0,      // First write word
    input  wire logic [DW-1:0] wr_data1,      // Second write word
    input  wire logic          rd_valid,      // Read request
    output      logic          rd_ready,      // Read taken
    input  wire logic [AW-1:0] rd_addr,       // Read address
    output      logic          rsp_valid,     // Burst available
    input  wire logic          rsp_ready,     // Burst consumed
    output      logic [DW-1:0] rsp_data0,     // First read word
    output      logic [DW-1:0] rsp_data1      // Second read word
);

    localparam int RW = 3 + DW;
    localparam int DP = `DBS_RSP_DEPTH;

    // ----------------------------------------------------------------
    // Link clock divider
    // ----------------------------------------------------------------
    logic [15:0]        cnt_q;
    dbs_pkg::dbs_phase_e ph_q;
    logic               edge_k;
    logic               edge_kn;
    logic               k_q;

    // True clock rises when the DBS_PH_TRUE count ends
    assign edge_k  = (cnt_q == 16'(HALF - 1)) && ph_q == dbs_pkg::DBS_PH_TRUE;
    assign edge_kn = (cnt_q == 16'(HALF - 1)) && ph_q == dbs_pkg::DBS_PH_COMP;

    // Divide ref_clk into the k pair
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt_q <= 16'h0;
            ph_q  <= dbs_pkg::DBS_PH_TRUE;
            k_q   <= 1'h0;
        end
        else if (edge_k || edge_kn)
        begin
            cnt_q <= 16'h0;
            ph_q  <= edge_k ? dbs_pkg::DBS_PH_COMP : dbs_pkg::DBS_PH_TRUE;
            k_q   <= edge_k;
        end
        else
            cnt_q <= cnt_q + 16'h1;
    end

    // ----------------------------------------------------------------
    // Request launch
    // ----------------------------------------------------------------
    logic [1:0]    outst_q;
    logic [1:0]    fill_q;
    logic          rd_go;
    logic          wr_go;
    logic [AW-1:0] addr_q;
    logic [DW-1:0] d_q;
    logic [AW-1:0] wa_q;
    logic [DW-1:0] wd1_q;
    logic          rps_n_q;
    logic          wps_n_q;
    logic          cfg_s_q;
    logic          cfg_p_q;
    logic          push;

    // Reads only launch while the response buffer has room
    assign wr_ready = edge_k;
    assign rd_ready = edge_k && ({1'h0, outst_q} + {1'h0, fill_q}) < 3'(DP);
    assign wr_go    = wr_valid & wr_ready;
    assign rd_go    = rd_valid & rd_ready;

    // Read address on k, write address and second word on k_n
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_q  <= '0;
            d_q     <= '0;
            wa_q    <= '0;
            wd1_q   <= '0;
            rps_n_q <= 1'h1;
            wps_n_q <= 1'h1;
            cfg_s_q <= 1'h0;
            cfg_p_q <= 1'h1;
        end
        else if (edge_k)
        begin
            addr_q  <= rd_addr;
            rps_n_q <= ~rd_go;
            wps_n_q <= ~wr_go;
            d_q     <= wr_data0;
            wa_q    <= wr_addr;
            wd1_q   <= wr_data1;
            cfg_s_q <= single_cfg;
            cfg_p_q <= pll_cfg;
        end
        else if (edge_kn)
        begin
            addr_q  <= wa_q;
            d_q     <= wd1_q;
            rps_n_q <= 1'h1;
        end
    end

    // Reads in flight
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            outst_q <= 2'h0;
        else
            outst_q <= outst_q + {1'h0, rd_go} - {1'h0, push};
    end

    assign link.k                   = k_q;
    assign link.k_n                 = ~k_q;
    assign link.c                   = k_q;
    assign link.c_n                 = ~k_q;
    assign link.single_clock        = cfg_s_q;
    assign link.pll_disable         = cfg_p_q;
    assign link.addr                = addr_q;
    assign link.d                   = d_q;
    assign link.read_port_select_n  = rps_n_q;
    assign link.write_port_select_n = wps_n_q;

    // ----------------------------------------------------------------
    // Read capture on echo clocks
    // ----------------------------------------------------------------
    logic [RW-1:0] rmeta_q;
    logic [RW-1:0] rsync_q;
    logic [1:0]    eprev_q;
    logic          echo_edge;
    logic          half_q;
    logic [DW-1:0] hold_q;

    // Two flip-flops on every returning pin
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // Echo complement idles high, so no false edge follows reset
            rmeta_q <= {2'h1, {(RW - 2){1'h0}}};
            rsync_q <= {2'h1, {(RW - 2){1'h0}}};
            eprev_q <= 2'h1;
        end
        else
        begin
            rmeta_q <= {link.echo_clock_pair, link.echo_clock_pair_n, link.read_data_valid, link.q};
            rsync_q <= rmeta_q;
            eprev_q <= rsync_q[RW-1:RW-2];
        end
    end

    assign echo_edge = |(rsync_q[RW-1:RW-2] & ~eprev_q);
    assign push      = echo_edge & rsync_q[DW] & half_q;

    // Pair words into bursts
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            half_q <= 1'h0;
            hold_q <= '0;
        end
        else if (echo_edge && rsync_q[DW])
        begin
            half_q <= ~half_q;
            hold_q <= rsync_q[DW-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Two-entry response buffer
    // ----------------------------------------------------------------
    logic [2*DW-1:0] buf_q [0:DP-1];
    logic            wp_q;
    logic            rp_q;
    logic            pop;

    assign pop       = rsp_valid & rsp_ready;
    assign rsp_valid = fill_q != 2'h0;
    assign {rsp_data1, rsp_data0} = buf_q[rp_q];

    // Pointers and fill level
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wp_q   <= 1'h0;
            rp_q   <= 1'h0;
            fill_q <= 2'h0;
            for (int i = 0; i < DP; i++)
                buf_q[i] <= '0;
        end
        else
        begin
            if (push)
            begin
                buf_q[wp_q] <= {rsync_q[DW-1:0], hold_q};
                wp_q        <= ~wp_q;
            end
            if (pop)
                rp_q <= ~rp_q;
            fill_q <= fill_q + {1'h0, push} - {1'h0, pop};
        end
    end

endmodule

// File: verification/dbs_link_chk.sv
`timescale 1ns/1ns

module dbs_link_chk #(
    parameter int DW = 18,
    parameter int AW = 8
) (
    input wire logic          ref_clk,              // System clock
    input wire logic          reset_n,              // Reset, active low
    input wire logic          k,                    // Input clock, true
    input wire logic          k_n,                  // Input clock, complement
    input wire logic          c,                    // Output clock, true
    input wire logic          c_n,                  // Output clock, complement
    input wire logic          pll_disable,          // Latency select
    input wire logic          read_port_select_n,   // Read select
    input wire logic          write_port_select_n,  // Write select
    input wire logic [AW-1:0] addr,                 // Shared address
    input wire logic [DW-1:0] d,                    // Write data
    input wire logic [DW-1:0] q,                    // Read data
    input wire logic          read_data_valid,      // Read word present
    input wire logic          echo_clock_pair,      // Echo clock, true
    input wire logic          echo_clock_pair_n     // Echo clock, complement
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // ----------------------------------------------------------------
    // Burst sequences
    // ----------------------------------------------------------------
    sequence rd_slow_s;
        $rose(k) && !read_port_select_n && pll_disable;
    endsequence
    sequence rd_fast_s;
        $rose(k) && !read_port_select_n && !pll_disable;
    endsequence
    sequence wr_first_s;
        (!write_port_select_n && k)[*6];
    endsequence

    // ----------------------------------------------------------------
    // Link checks
    // ----------------------------------------------------------------
    kpair_compl_a: assert property (k_n == ~k) else $error("k pair not complementary");
    cpair_compl_a: assert property (c_n == ~c) else $error("c pair not complementary");
    echo_compl_a: assert property (echo_clock_pair_n == ~echo_clock_pair) else $error("echo pair skew");
    k_half_a: assert property ($rose(k) |-> k[*6] ##1 !k) else $error("k half period wrong");
    addr_edge_a: assert property ($changed(addr) |-> $changed(k)) else $error("addr off k edge");
    data_edge_a: assert property ($changed(d) |-> $changed(k)) else $error("d off k edge");
    rsel_edge_a: assert property ($changed(read_port_select_n) |-> $changed(k)) else $error("read select moved");
    wr_burst_a: assert property ($rose(k) && !write_port_select_n |-> wr_first_s ##1
        ($rose(k_n) && !write_port_select_n)) else $error("write burst broken");
    echo_align_a: assert property ($changed(q) || $changed(read_data_valid) |-> $changed(echo_clock_pair))
        else $error("read data not on echo edge");
    echo_space_a: assert property ($changed(echo_clock_pair) |=> $stable(echo_clock_pair)[*4])
        else $error("echo edges too close");
    lat_slow_a: assert property (rd_slow_s |-> ##[17:23] read_data_valid) else $error("slow latency");
    lat_fast_a: assert property (rd_fast_s |-> ##[11:17] read_data_valid) else $error("fast latency");
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ns
`include "dbs_map.svh"

module tb_top;
    localparam int DW = `DBS_DATA_W;
    localparam int AW = `DBS_ADDR_W;
    logic          ref_clk, reset_n, single_cfg, pll_cfg, stall;
    logic          wr_valid, wr_ready, rd_valid, rd_ready, rsp_valid, rsp_ready;
    logic          write_commit, read_launch, busy;
    logic [AW-1:0] wr_addr, rd_addr, dev_waddr;
    logic [DW-1:0] wr_data0, wr_data1, rsp_data0, rsp_data1;
    logic [DW-1:0] mem0 [256];
    logic [DW-1:0] mem1 [256];
    logic [DW-1:0] exp_q [$];
    logic [AW-1:0] wa_q [$];
    int            seed = 32'haaaad28b;
    int            mismatches, compares, n_wr, n_rd, n_commit, n_launch;

    dbs_link_if #(.DW(DW), .AW(AW)) link ();
    dbs_host dbs_host_i (.ref_clk(ref_clk), .reset_n(reset_n), .link(link), .single_cfg(single_cfg),
        .pll_cfg(pll_cfg), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data0(wr_data0),
        .wr_data1(wr_data1), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_addr(rd_addr),
        .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data0(rsp_data0), .rsp_data1(rsp_data1));
    dbs_device dbs_device_i (.ref_clk(ref_clk), .reset_n(reset_n), .link(link),
        .write_commit(write_commit), .write_addr(dev_waddr), .read_launch(read_launch));
    dbs_link_chk #(.DW(DW), .AW(AW)) dbs_link_chk_i (.ref_clk(ref_clk), .reset_n(reset_n),
        .k(link.k), .k_n(link.k_n), .c(link.c), .c_n(link.c_n), .pll_disable(link.pll_disable),
        .read_port_select_n(link.read_port_select_n), .write_port_select_n(link.write_port_select_n),
        .addr(link.addr), .d(link.d), .q(link.q), .read_data_valid(link.read_data_valid),
        .echo_clock_pair(link.echo_clock_pair), .echo_clock_pair_n(link.echo_clock_pair_n));

    // ----------------------------------------------------------------
    // Clock and shared tasks
    // ----------------------------------------------------------------
    initial ref_clk = 1'b0;
    always #(`DBS_CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Small address set plus the top address, so collisions are frequent
    function automatic logic [AW-1:0] adr(int v);
        return ((v & 15) == 15) ? 8'hff : AW'(v & 15);
    endfunction

    // Offer a write and/or a read, hold each until taken, update the model
    task automatic do_op(logic w, logic r, logic [AW-1:0] a_w, logic [AW-1:0] a_r);
        logic wd, rdn;
        int   t;
        @(negedge ref_clk);
        wr_valid = w;
        rd_valid = r;
        wr_addr  = a_w;
        rd_addr  = a_r;
        wr_data0 = DW'($random(seed));
        wr_data1 = DW'($random(seed));
        t = 0;
        while ((wr_valid || rd_valid) && t < 400)
        begin
            #1;
            rdn = rd_valid && rd_ready === 1'b1;
            wd  = wr_valid && wr_ready === 1'b1;
            if (rdn)
            begin
                exp_q.push_back(mem0[rd_addr]);
                exp_q.push_back(mem1[rd_addr]);
                n_rd++;
            end
            if (wd)
            begin
                mem0[wr_addr] = wr_data0;
                mem1[wr_addr] = wr_data1;
                wa_q.push_back(wr_addr);
                n_wr++;
            end
            @(negedge ref_clk);
            if (wd) wr_valid = 1'b0;
            if (rdn) rd_valid = 1'b0;
            t++;
        end
        check("request taken", 32'(wr_valid | rd_valid), 0);
    endtask

    task automatic drain();
        int t;
        t = 0;
        while ((exp_q.size() > 0 || wa_q.size() > 0) && t < 2000)
        begin
            @(negedge ref_clk);
            t++;
        end
        check("pending", 32'(exp_q.size() + wa_q.size()), 0);
    endtask

    // ----------------------------------------------------------------
    // Response side and device-side monitors
    // ----------------------------------------------------------------
    always @(negedge ref_clk)
    begin
        rsp_ready = !stall && (($random(seed) & 1) != 0);
        #1;
        if (rsp_valid === 1'b1 && rsp_ready)
        begin
            check("rsp_data0", rsp_data0, exp_q.pop_front());
            check("rsp_data1", rsp_data1, exp_q.pop_front());
        end
    end

    always @(negedge ref_clk)
    begin
        if (reset_n && write_commit === 1'b1)
        begin
            n_commit++;
            check("write_addr", dev_waddr, wa_q.pop_front());
        end
        if (reset_n && read_launch === 1'b1) n_launch++;
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {reset_n, single_cfg, pll_cfg, stall, wr_valid, rd_valid, rsp_ready} = 7'h10;
        {wr_addr, rd_addr, wr_data0, wr_data1} = '0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk) reset_n = 1'b1;
        for (int a = 0; a < 16; a++) do_op(1'b1, 1'b0, adr(a), '0);
        // Every latency and clocking mode, random concurrent traffic
        for (int m = 0; m < 4; m++)
        begin
            {single_cfg, pll_cfg} = 2'(m);
            repeat (30) do_op(1'($random(seed)), 1'($random(seed)), adr($random(seed)), adr($random(seed)));
            do_op(1'b1, 1'b0, adr(7), '0);
            do_op(1'b0, 1'b1, '0, adr(7));
            drain();
        end
        // Stalled consumer: two bursts buffered, further reads refused
        stall = 1'b1;
        do_op(1'b0, 1'b1, '0, adr(1));
        do_op(1'b0, 1'b1, '0, adr(2));
        busy = 1'b0;
        repeat (60)
        begin
            @(negedge ref_clk);
            #1;
            busy = busy | (rd_ready === 1'b1);
        end
        check("read credit", 32'(busy), 0);
        stall = 1'b0;
        drain();
        // Second reset: array contents survive
        reset_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        reset_n = 1'b1;
        do_op(1'b0, 1'b1, '0, adr(5));
        drain();
        check("commits", 32'(n_commit), 32'(n_wr));
        check("launches", 32'(n_launch), 32'(n_rd));
        print_verdict();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #400000;
        mismatches++;
        print_verdict();
    end
endmodule
